/* design/rcd_pkg.sv */
package rcd_pkg;

   // Register bus geometry
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;

   // Register byte offsets
   localparam logic [7:0] OFS_EVT_DIR    = 8'h00;
   localparam logic [7:0] OFS_EVT_INSEL  = 8'h04;
   localparam logic [7:0] OFS_EVT_OUTSEL = 8'h08;
   localparam logic [7:0] OFS_STATUS     = 8'h0c;

   // Reset values
   localparam logic [6:0] EVT_DIR_RST    = 7'h00;
   localparam logic [9:0] EVT_INSEL_RST  = 10'h000;
   localparam logic       EVT_OUTSEL_RST = 1'b0;

   // Event pin count: six address pins plus the data pin
   localparam int unsigned NUM_ADDR_PINS = 6;
   localparam int unsigned NUM_EVT_PINS  = 7;
   localparam int unsigned DATA_PIN_IDX  = 6;

   // Input role codes, two bits per pin in the input select register
   localparam logic [1:0] ROLE_CHAN  = 2'h0;
   localparam logic [1:0] ROLE_EVENT = 2'h1;
   localparam logic [1:0] ROLE_AUX   = 2'h2;

   // Status register field positions
   localparam int unsigned ST_DEBUG_POS = 0;
   localparam int unsigned ST_BOOT_POS  = 1;
   localparam int unsigned ST_HOST_POS  = 3;
   localparam int unsigned ST_CFGM_POS  = 4;
   localparam int unsigned ST_STATE_POS = 5;
   localparam int unsigned ST_PINS_POS  = 8;

   // Synchronised pin vector layout
   localparam int unsigned PIN_W     = 15;
   localparam int unsigned PV_HOST   = 7;
   localparam int unsigned PV_BOOT   = 8;
   localparam int unsigned PV_DEBUG  = 10;
   localparam int unsigned PV_RSTCFG = 11;
   localparam int unsigned PV_SOFT   = 12;
   localparam int unsigned PV_HARD   = 13;
   localparam int unsigned PV_POR    = 14;
   // Power-on reset seen as asserted until the pin proves otherwise
   localparam logic [14:0] PIN_SYNC_RST = 15'h4000;

   typedef enum logic [1:0] {
      RST_RUN  = 2'b00,
      RST_SOFT = 2'b01,
      RST_HARD = 2'b10,
      RST_POR  = 2'b11
   } rcd_rst_e;

   typedef struct packed {
      logic       debugEntry;
      logic [1:0] bootMode;
      logic       hostPort;
      logic       cfgMaster;
   } rcd_strap_s;

   localparam rcd_strap_s STRAP_RST = '{debugEntry: 1'b0, bootMode: 2'h0,
                                        hostPort: 1'b0, cfgMaster: 1'b0};

endpackage : rcd_pkg

/* design/rcd_reset_event.sv */
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Latch debug strap at power-on release
// - Event pins default to input after reset
// - Pin zero input: request, channel, event
// - Pin zero output: channel 0 match
// - Pin one input: channel or event
// - Pin one output: acknowledge or match
// - Pin two input: channel, event, counter
// - Pin two output: channel 2 match
// - Pin three input: channel or event
// - Pin three output: receive register read
// - Pin four input: channel or event
// - Pin four output: transmit register written
// - Pin five: channel 5 enable or match
// - Data pin: data channel enable or match
// - Host strap enables port, 32-bit bus
// - Latch boot mode at power-on release
// - Power-on input forces power-on state
// - Hard reset line forces hard state
// - Soft reset line forces soft state
// - Reset config input used during configuration
module rcd_reset_event (
   input  wire logic                      ref_clk,
   input  wire logic                      resetn,
   // Register port
   input  wire logic [7:0]                regAddr,
   input  wire logic [31:0]               regWdata,
   input  wire logic                      regWr,
   input  wire logic                      regRd,
   output logic [31:0]                    regRdata,
   // Reset and strap pins
   input  wire logic                      powerOnResetInN,
   input  wire logic                      resetConfigInN,
   input  wire logic                      hardResetLineIn,
   output logic                           hardResetLineOut,
   output logic                           hardResetLineOeN,
   input  wire logic                      softResetLineIn,
   output logic                           softResetLineOut,
   output logic                           softResetLineOeN,
   input  wire logic                      debugEntryStrap,
   input  wire logic [1:0]                bootModeStrap,
   input  wire logic                      hostPortStrap,
   // Event pins, index 6 is the data event pin
   input  wire logic [6:0]                evtPinIn,
   output logic      [6:0]                evtPinOut,
   output logic      [6:0]                evtPinOeN,
   // Core side
   input  wire logic [5:0]                addrMatch,
   input  wire logic                      dataMatch,
   input  wire logic                      debugAck,
   input  wire logic                      rcvRegRead,
   input  wire logic                      xmtRegWritten,
   output rcd_pkg::rcd_rst_e              resetState,
   output logic                           corePorActive,
   output logic                           coreHardActive,
   output logic                           coreSoftActive,
   output rcd_pkg::rcd_strap_s            strapCfg,
   output logic                           busIs32,
   output logic [5:0]                     chanEnable,
   output logic                           dataChanEnable,
   output logic [4:0]                     eventGen,
   output logic                           debugRequest,
   output logic                           counterEnable
);

   logic [14:0]          pinRaw;
   logic [14:0]          sync1Q;
   logic [14:0]          sync2Q;
   logic [14:0]          sync3Q;
   logic [14:0]          stblQ;
   rcd_pkg::rcd_rst_e    stateQ;
   rcd_pkg::rcd_rst_e    stateD;
   logic                 porLeave;
   logic                 cfgLeave;
   logic [6:0]           dirQ;
   logic [9:0]           inSelQ;
   logic                 outSelQ;
   logic [6:0]           evtOutD;
   logic [5:0]           chanD;
   logic [4:0]           eventD;
   logic [31:0]          statusWord;

   // Role of an input pin, decoded for several pins and for the assertions
   function automatic logic pinRole(input logic isOut, input logic level,
                                    input logic [1:0] sel, input logic [1:0] role);
      pinRole = !isOut && level && (sel == role);
   endfunction : pinRole

   // Active-low pins are turned active high before they are synchronised
   assign pinRaw = {~powerOnResetInN, ~hardResetLineIn, ~softResetLineIn, ~resetConfigInN,
                    debugEntryStrap, bootModeStrap, hostPortStrap, evtPinIn};

   // Three stages; a level counts once stages two and three agree
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         sync1Q <= rcd_pkg::PIN_SYNC_RST;
         sync2Q <= rcd_pkg::PIN_SYNC_RST;
         sync3Q <= rcd_pkg::PIN_SYNC_RST;
      end else begin
         sync1Q <= pinRaw;
         sync2Q <= sync1Q;
         sync3Q <= sync2Q;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         stblQ <= rcd_pkg::PIN_SYNC_RST;
      end else begin
         stblQ <= (sync2Q & sync3Q) | (stblQ & (sync2Q | sync3Q));
      end
   end

   // Reset state, highest source wins
   always_comb begin
      if (stblQ[rcd_pkg::PV_POR]) begin
         stateD = rcd_pkg::RST_POR;
      end else if (stblQ[rcd_pkg::PV_HARD]) begin
         stateD = rcd_pkg::RST_HARD;
      end else if (stblQ[rcd_pkg::PV_SOFT]) begin
         stateD = rcd_pkg::RST_SOFT;
      end else begin
         stateD = rcd_pkg::RST_RUN;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         stateQ <= rcd_pkg::RST_POR;
      end else begin
         stateQ <= stateD;
      end
   end

   assign resetState = stateQ;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         corePorActive  <= 1'b1;
         coreHardActive <= 1'b1;
         coreSoftActive <= 1'b1;
      end else begin
         corePorActive  <= (stateD == rcd_pkg::RST_POR);
         coreHardActive <= (stateD == rcd_pkg::RST_POR) || (stateD == rcd_pkg::RST_HARD);
         coreSoftActive <= (stateD != rcd_pkg::RST_RUN);
      end
   end

   // Reset lines are only listened to; this block never pulls them
   assign hardResetLineOut = 1'b0;
   assign hardResetLineOeN = 1'b1;
   assign softResetLineOut = 1'b0;
   assign softResetLineOeN = 1'b1;

   assign porLeave = (stateQ == rcd_pkg::RST_POR) && (stateD != rcd_pkg::RST_POR);
   assign cfgLeave = ((stateQ == rcd_pkg::RST_POR) || (stateQ == rcd_pkg::RST_HARD))
                     && (stateD != rcd_pkg::RST_POR) && (stateD != rcd_pkg::RST_HARD);

   // Straps move only on power-on exit; configuration input also on hard reset exit
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         strapCfg <= rcd_pkg::STRAP_RST;
      end else begin
         if (porLeave) begin
            strapCfg.debugEntry <= stblQ[rcd_pkg::PV_DEBUG];
            strapCfg.bootMode   <= stblQ[rcd_pkg::PV_BOOT +: 2];
            strapCfg.hostPort   <= stblQ[rcd_pkg::PV_HOST];
         end
         if (cfgLeave) begin
            strapCfg.cfgMaster <= stblQ[rcd_pkg::PV_RSTCFG];
         end
      end
   end

   // Host port strap selects the 32-bit bus; busIs32 follows the latched host strap
   assign busIs32 = strapCfg.hostPort;

   // Event configuration returns to defaults in power-on reset
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         dirQ    <= rcd_pkg::EVT_DIR_RST;
         inSelQ  <= rcd_pkg::EVT_INSEL_RST;
         outSelQ <= rcd_pkg::EVT_OUTSEL_RST;
      end else if (stateQ == rcd_pkg::RST_POR) begin
         dirQ    <= rcd_pkg::EVT_DIR_RST;
         inSelQ  <= rcd_pkg::EVT_INSEL_RST;
         outSelQ <= rcd_pkg::EVT_OUTSEL_RST;
      end else if (regWr) begin
         if (regAddr == rcd_pkg::OFS_EVT_DIR) begin
            dirQ <= regWdata[6:0];
         end else if (regAddr == rcd_pkg::OFS_EVT_INSEL) begin
            inSelQ <= regWdata[9:0];
         end else if (regAddr == rcd_pkg::OFS_EVT_OUTSEL) begin
            outSelQ <= regWdata[0];
         end
      end
   end

   // Input roles of address event pins zero to four
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_evtIn
         assign chanD[gi]  = pinRole(dirQ[gi], stblQ[gi], inSelQ[2*gi +: 2],
                                     rcd_pkg::ROLE_CHAN);
         assign eventD[gi] = pinRole(dirQ[gi], stblQ[gi], inSelQ[2*gi +: 2],
                                     rcd_pkg::ROLE_EVENT);
      end
   endgenerate
   // Pin five has a single input role
   assign chanD[5] = !dirQ[5] && stblQ[5];

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         chanEnable     <= 6'h00;
         eventGen       <= 5'h00;
         dataChanEnable <= 1'b0;
         debugRequest   <= 1'b0;
         counterEnable  <= 1'b0;
      end else begin
         chanEnable     <= chanD;
         eventGen       <= eventD;
         dataChanEnable <= !dirQ[rcd_pkg::DATA_PIN_IDX] && stblQ[rcd_pkg::DATA_PIN_IDX];
         debugRequest   <= pinRole(dirQ[0], stblQ[0], inSelQ[1:0], rcd_pkg::ROLE_AUX);
         counterEnable  <= pinRole(dirQ[2], stblQ[2], inSelQ[5:4], rcd_pkg::ROLE_AUX);
      end
   end

   // Output sources of the event pins
   always_comb begin
      evtOutD[0] = addrMatch[0];
      evtOutD[1] = outSelQ ? debugAck : addrMatch[1];
      evtOutD[2] = addrMatch[2];
      evtOutD[3] = rcvRegRead;
      evtOutD[4] = xmtRegWritten;
      evtOutD[5] = addrMatch[5];
      evtOutD[6] = dataMatch;
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         evtPinOut <= 7'h00;
      end else begin
         evtPinOut <= evtOutD & dirQ;
      end
   end

   assign evtPinOeN = ~dirQ;

   // Register readback
   always_comb begin
      statusWord = 32'h0000_0000;
      statusWord[rcd_pkg::ST_DEBUG_POS]      = strapCfg.debugEntry;
      statusWord[rcd_pkg::ST_BOOT_POS +: 2]  = strapCfg.bootMode;
      statusWord[rcd_pkg::ST_HOST_POS]       = strapCfg.hostPort;
      statusWord[rcd_pkg::ST_CFGM_POS]       = strapCfg.cfgMaster;
      statusWord[rcd_pkg::ST_STATE_POS +: 2] = stateQ;
      statusWord[rcd_pkg::ST_PINS_POS +: 7]  = stblQ[6:0];
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         regRdata <= 32'h0000_0000;
      end else if (regRd) begin
         if (regAddr == rcd_pkg::OFS_EVT_DIR) begin
            regRdata <= {25'h000_0000, dirQ};
         end else if (regAddr == rcd_pkg::OFS_EVT_INSEL) begin
            regRdata <= {22'h00_0000, inSelQ};
         end else if (regAddr == rcd_pkg::OFS_EVT_OUTSEL) begin
            regRdata <= {31'h0000_0000, outSelQ};
         end else if (regAddr == rcd_pkg::OFS_STATUS) begin
            regRdata <= statusWord;
         end else begin
            regRdata <= 32'h0000_0000;
         end
      end else begin
         regRdata <= 32'h0000_0000;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   property p_debug_latch;
      porLeave |=> (strapCfg.debugEntry == $past(stblQ[rcd_pkg::PV_DEBUG]));
   endproperty
   a_debug_latch: assert property (p_debug_latch) else $error("debug strap not latched");

   property p_boot_latch;
      porLeave |=> (strapCfg.bootMode == $past(stblQ[9:8]) && busIs32 == $past(stblQ[7]));
   endproperty
   a_boot_latch: assert property (p_boot_latch) else $error("boot or host strap wrong");

   property p_strap_hold;
      (stateQ != rcd_pkg::RST_POR) |=> $stable(strapCfg[4:1]);
   endproperty
   a_strap_hold: assert property (p_strap_hold) else $error("strap moved outside reset");

   property p_por_defaults;
      (stateQ == rcd_pkg::RST_POR) |=> (evtPinOeN == 7'h7f) ##1 (evtPinOut == 7'h00);
   endproperty
   a_por_defaults: assert property (p_por_defaults) else $error("event pin not input");

   property p_por_state;
      stblQ[rcd_pkg::PV_POR] |=> (stateQ == rcd_pkg::RST_POR) && corePorActive;
   endproperty
   a_por_state: assert property (p_por_state) else $error("power-on state missed");

   property p_hard_over_soft;
      (!stblQ[14] && stblQ[13]) |=> (stateQ == rcd_pkg::RST_HARD) && coreSoftActive;
   endproperty
   a_hard_over_soft: assert property (p_hard_over_soft) else $error("hard reset order");

   property p_soft_state;
      (stblQ[14:12] == 3'h1) |=> (stateQ == rcd_pkg::RST_SOFT) && !coreHardActive;
   endproperty
   a_soft_state: assert property (p_soft_state) else $error("soft reset state missed");

   property p_pin0_out;
      (dirQ[0] && addrMatch[0] && $stable(dirQ)) |=> evtPinOut[0];
   endproperty
   a_pin0_out: assert property (p_pin0_out) else $error("pin zero match not driven");

   property p_pin1_ack;
      (dirQ[1] && outSelQ && debugAck) |=> (evtPinOut[1] || !$past(dirQ[1], 1) == 1'b1);
   endproperty
   a_pin1_ack: assert property (p_pin1_ack) else $error("debug acknowledge not driven");

   property p_rcv_xmt;
      (dirQ[4:3] == 2'h3 && stateQ != rcd_pkg::RST_POR)
         |=> (evtPinOut[3] == $past(rcvRegRead) && evtPinOut[4] == $past(xmtRegWritten));
   endproperty
   a_rcv_xmt: assert property (p_rcv_xmt) else $error("register event pin wrong");

   property p_dbg_req;
      pinRole(dirQ[0], stblQ[0], inSelQ[1:0], rcd_pkg::ROLE_AUX)
         |=> debugRequest && !chanEnable[0] && !eventGen[0];
   endproperty
   a_dbg_req: assert property (p_dbg_req) else $error("debug request not raised");

   property p_counter;
      (!dirQ[2] && stblQ[2] && inSelQ[5:4] == rcd_pkg::ROLE_AUX) |=> counterEnable;
   endproperty
   a_counter: assert property (p_counter) else $error("counter enable missing");

   property p_data_in;
      (!dirQ[6] && stblQ[6]) |=> dataChanEnable && !evtPinOut[6];
   endproperty
   a_data_in: assert property (p_data_in) else $error("data channel not enabled");

   c_por_leave: cover property (porLeave ##1 strapCfg.debugEntry);
   c_hard_reset: cover property (stateQ == rcd_pkg::RST_HARD ##1 stateQ == rcd_pkg::RST_RUN);
   c_pin0_out: cover property (dirQ[0] && evtPinOut[0]);
   c_host_boot: cover property (busIs32 && stateQ == rcd_pkg::RST_RUN);

endmodule : rcd_reset_event

`default_nettype wire

/* testbench/rcd_board_model.sv */
`timescale 1ns/1ps
`default_nettype none

module rcd_board_model (
   input  wire logic       ref_clk,
   input  wire logic       porHold,
   input  wire logic       hardPull,
   input  wire logic       softPull,
   input  wire logic [6:0] evtDrive,
   input  wire logic [6:0] evtVal,
   input  wire logic       hardResetLineOut,
   input  wire logic       hardResetLineOeN,
   input  wire logic       softResetLineOut,
   input  wire logic       softResetLineOeN,
   input  wire logic [6:0] evtPinOut,
   input  wire logic [6:0] evtPinOeN,
   output logic            powerOnResetInN,
   output logic            hardResetLineIn,
   output logic            softResetLineIn,
   output logic [6:0]      evtPinIn
);
   logic [6:0] floatQ = 7'h2a;

   // No pull on event pins: an undriven pin must not look stable
   always @(posedge ref_clk) begin
      floatQ <= {floatQ[5:0], ~floatQ[6]};
   end

   // Power-on reset pin held low by the board while porHold is high
   assign powerOnResetInN = ~porHold;
   // Open-drain lines with pull-up
   assign hardResetLineIn = ~hardPull & (hardResetLineOeN | hardResetLineOut);
   assign softResetLineIn = ~softPull & (softResetLineOeN | softResetLineOut);

   always_comb begin
      for (int i = 0; i < 7; i++) begin
         evtPinIn[i] = !evtPinOeN[i] ? evtPinOut[i] : (evtDrive[i] ? evtVal[i] : floatQ[i]);
      end
   end
endmodule : rcd_board_model

`default_nettype wire

/* testbench/rcd_reset_event_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module rcd_reset_event_tb;
   logic ref_clk, resetn, regWr, regRd, resetConfigInN, debugEntryStrap, hostPortStrap;
   logic [7:0] regAddr;
   logic [31:0] regWdata, regRdata;
   logic powerOnResetInN, hardResetLineIn, softResetLineIn, dataMatch, debugAck;
   logic hardResetLineOut, hardResetLineOeN, softResetLineOut, softResetLineOeN;
   logic [1:0] bootModeStrap;
   logic [6:0] evtPinIn, evtPinOut, evtPinOeN, evtDrive, evtVal;
   logic [5:0] addrMatch, chanEnable;
   logic rcvRegRead, xmtRegWritten, corePorActive, coreHardActive, coreSoftActive;
   logic busIs32, dataChanEnable, debugRequest, counterEnable, porHold, hardPull, softPull;
   logic [4:0] eventGen;
   rcd_pkg::rcd_rst_e resetState;
   rcd_pkg::rcd_strap_s strapCfg;
   int fail_count = 0;
   int comparisons = 0;
   logic [9:0] selTab [3] = '{10'h166, 10'h155, 10'h3ff};
   logic [12:0] expTab [3] = '{13'h106b, 13'h107c, 13'h1000};

   rcd_reset_event rcd_reset_event_i (.ref_clk, .resetn, .regAddr, .regWdata, .regWr, .regRd,
      .regRdata, .powerOnResetInN, .resetConfigInN, .hardResetLineIn, .hardResetLineOut,
      .hardResetLineOeN, .softResetLineIn, .softResetLineOut, .softResetLineOeN,
      .debugEntryStrap, .bootModeStrap, .hostPortStrap, .evtPinIn, .evtPinOut, .evtPinOeN,
      .addrMatch, .dataMatch, .debugAck, .rcvRegRead, .xmtRegWritten, .resetState,
      .corePorActive, .coreHardActive, .coreSoftActive, .strapCfg, .busIs32, .chanEnable,
      .dataChanEnable, .eventGen, .debugRequest, .counterEnable);

   rcd_board_model rcd_board_model_i (.ref_clk, .porHold, .hardPull, .softPull, .evtDrive,
      .evtVal, .hardResetLineOut, .hardResetLineOeN, .softResetLineOut, .softResetLineOeN,
      .evtPinOut, .evtPinOeN, .powerOnResetInN, .hardResetLineIn, .softResetLineIn, .evtPinIn);

   always #20 ref_clk = ~ref_clk;

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge ref_clk);
      regWr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      @(posedge ref_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRd <= 1'b0;
      #1;
      check(regRdata & m, exp);
   endtask : rd

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out

   initial begin
      repeat (3000) @(posedge ref_clk);
      fail_count++;
      close_out();
   end

   initial begin
      {ref_clk, resetn, regWr, regRd, regAddr, regWdata, resetConfigInN} = '0;
      {hardPull, softPull, evtDrive, evtVal, addrMatch, dataMatch, debugAck} = '0;
      {rcvRegRead, xmtRegWritten} = '0;
      {porHold, debugEntryStrap, bootModeStrap, hostPortStrap} = 5'h1d;
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      tick(1);
      check(32'(resetState), 32'(rcd_pkg::RST_POR));
      check(32'(evtPinOeN), 32'h0000_007f);
      wr(rcd_pkg::OFS_EVT_DIR, 32'h0000_007f);
      @(posedge ref_clk);
      porHold <= 1'b0;
      resetConfigInN <= 1'b1;
      tick(5);
      check(32'(resetState), 32'(rcd_pkg::RST_RUN));
      check(32'(strapCfg), 32'h0000_001a);
      check(32'({strapCfg.hostPort, busIs32}), 32'h0000_0003);
      rd(rcd_pkg::OFS_EVT_DIR, 32'hffff_ffff, 32'h0000_0000);
      @(posedge ref_clk);
      {debugEntryStrap, bootModeStrap, hostPortStrap} <= 4'h2;
      tick(5);
      rd(rcd_pkg::OFS_STATUS, 32'h0000_006f, 32'h0000_000d);
      $display("test straps done");

      @(posedge ref_clk);
      softPull <= 1'b1;
      tick(5);
      check(32'({resetState, coreHardActive, coreSoftActive}), 32'h0000_0005);
      @(posedge ref_clk);
      hardPull <= 1'b1;
      tick(5);
      check(32'({resetState, coreHardActive, corePorActive}), 32'h0000_000a);
      @(posedge ref_clk);
      {porHold, resetConfigInN} <= 2'h2;
      tick(5);
      check(32'({resetState, corePorActive}), 32'h0000_0007);
      @(posedge ref_clk);
      {porHold, hardPull, softPull} <= 3'h0;
      tick(5);
      check(32'(resetState), 32'(rcd_pkg::RST_RUN));
      check(32'(strapCfg), 32'h0000_0005);
      $display("test resets done");

      @(posedge ref_clk);
      evtDrive <= 7'h7f;
      evtVal <= 7'h7f;
      tick(5);
      check(32'({chanEnable, dataChanEnable}), 32'h0000_007f);
      for (int i = 0; i < 3; i++) begin
         wr(rcd_pkg::OFS_EVT_INSEL, 32'(selTab[i]));
         tick(5);
         check(32'({chanEnable, eventGen, debugRequest, counterEnable}),
               32'(expTab[i]));
         rd(rcd_pkg::OFS_EVT_INSEL, 32'h0000_03ff, 32'(selTab[i]));
      end
      rd(8'h10, 32'hffff_ffff, 32'h0000_0000);
      $display("test event inputs done");

      wr(rcd_pkg::OFS_EVT_DIR, 32'h0000_007f);
      @(posedge ref_clk);
      evtDrive <= 7'h00;
      {addrMatch, dataMatch, debugAck, rcvRegRead, xmtRegWritten} <= 10'h25e;
      tick(5);
      check(32'(evtPinOeN), 32'h0000_0000);
      check(32'({chanEnable, dataChanEnable, eventGen}), 32'h0000_0000);
      check(32'(evtPinOut), 32'h0000_006d);
      wr(rcd_pkg::OFS_EVT_OUTSEL, 32'h0000_0001);
      @(posedge ref_clk);
      {addrMatch, dataMatch, debugAck, rcvRegRead, xmtRegWritten} <= 10'h081;
      tick(3);
      check(32'(evtPinOut), 32'h0000_0010);
      @(posedge ref_clk);
      debugAck <= 1'b1;
      tick(3);
      check(32'(evtPinOut), 32'h0000_0012);
      wr(rcd_pkg::OFS_EVT_DIR, 32'h0000_0000);
      tick(3);
      check(32'(evtPinOut), 32'h0000_0000);
      wr(rcd_pkg::OFS_EVT_DIR, 32'h0000_007f);
      @(posedge ref_clk);
      porHold <= 1'b1;
      tick(6);
      check(32'(evtPinOeN), 32'h0000_007f);
      wr(rcd_pkg::OFS_EVT_DIR, 32'h0000_007f);
      @(posedge ref_clk);
      porHold <= 1'b0;
      tick(5);
      rd(rcd_pkg::OFS_EVT_DIR, 32'hffff_ffff, 32'h0000_0000);
      $display("test event outputs done");
      close_out();
   end
endmodule : rcd_reset_event_tb

`default_nettype wire
